//--- pack_extend_bitfield_pkg.sv
// shared opcodes, field layouts and constants for the pack/extend/bitfield unit
package pack_extend_bitfield_pkg;

    localparam int WordBits = 32;
    localparam int HalfBits = 16;
    localparam int ByteBits = 8;
    localparam logic [4:0] ShiftAsrFull = 5'h00;
    localparam logic [5:0] AsrFullAmount = 6'h20;
    localparam logic [1:0] RotNone = 2'h0;
    localparam logic [1:0] Rot8 = 2'h1;
    localparam logic [1:0] Rot16 = 2'h2;
    localparam logic [1:0] Rot24 = 2'h3;

    typedef enum logic [4:0] {
        OP_PACK_LOW_HIGH_SHIFT_LEFT = 5'h00,
        OP_PACK_HIGH_LOW_SHIFT_RIGHT = 5'h01,
        OP_SIGN_EXT_BYTE = 5'h02,
        OP_SIGN_EXT_HALF = 5'h03,
        OP_DUAL_SIGN_EXT_BYTE = 5'h04,
        OP_ZERO_EXT_BYTE = 5'h05,
        OP_ZERO_EXT_HALF = 5'h06,
        OP_DUAL_ZERO_EXT_BYTE = 5'h07,
        OP_SIGN_EXT_BYTE_ADD = 5'h08,
        OP_SIGN_EXT_HALF_ADD = 5'h09,
        OP_DUAL_SIGN_EXT_BYTE_ADD = 5'h0a,
        OP_ZERO_EXT_BYTE_ADD = 5'h0b,
        OP_ZERO_EXT_HALF_ADD = 5'h0c,
        OP_DUAL_ZERO_EXT_BYTE_ADD = 5'h0d,
        OP_FIELD_CLEAR = 5'h0e,
        OP_FIELD_INSERT = 5'h0f,
        OP_SIGNED_FIELD_EXTRACT = 5'h10,
        OP_UNSIGNED_FIELD_EXTRACT = 5'h11
    } op_t;

    typedef struct packed {
        logic valid;
        logic condPass;
        op_t op;
        logic [31:0] firstSrcReg;
        logic [31:0] secondSrcReg;
        logic [31:0] destOld;
        logic [4:0] shiftAmount;
        logic [1:0] rotateRight;
        logic [4:0] fieldLsb;
        logic [5:0] fieldWidth;
        logic [3:0] flagsIn;
    } req_t;

    typedef struct packed {
        logic writeEn;
        logic [31:0] result;
        logic [3:0] flagsOut;
    } resp_t;

endpackage

//--- pack_extend_bitfield_unit.sv
// pack, extend and bitfield datapath with registered write-back
// What this block does
// RL1 - pack low-high: low half first, shifted second
// RL2 - left shift 1..31, zero means unshifted
// RL3 - pack high-low: high half first, shifted second
// RL4 - arithmetic right 1..32, field zero means 32
// RL5 - extends rotate source right 0/8/16/24 first
// RL6 - no rotation option means zero rotation
// RL7 - byte extend: bits 7..0 to 32 bits
// RL8 - half extend: bits 15..0 to 32 bits
// RL9 - dual byte extend into two halfwords
// RL10 - single extend-add adds first source word
// RL11 - dual extend-add adds matching halfwords
// RL12 - condition flags always pass through unchanged
// RL13 - field clear zeroes width bits at lsb
// RL14 - field insert copies low source bits in
// RL15 - lsb 0..31, width 1..32-lsb
// RL16 - signed extract sign-extends from field top
// RL17 - unsigned extract zero-fills above the field
// RL18 - sums wrap, dual sums carry nothing between halfwords
// RL19 - failed condition suppresses destination write
`timescale 1ns/1ps
module pack_extend_bitfield_unit
(
    input wire logic mclk,
    input wire logic rst,
    input wire pack_extend_bitfield_pkg::req_t req,
    output pack_extend_bitfield_pkg::resp_t resp,
    output logic rangeError
);

    logic [31:0] rotated;
    logic [31:0] extVal;
    logic [31:0] packVal;
    logic [31:0] fieldMask;
    logic [31:0] fieldVal;
    logic [31:0] result_d;
    logic [63:0] shlWide;
    logic signed [31:0] asrVal;
    logic [5:0] asrAmount;
    logic [5:0] topBit;
    logic [6:0] widthSum;
    logic badRange;
    logic isBitfield;
    logic [31:0] result_q;
    logic writeEn_q;
    logic [3:0] flags_q;
    logic rangeError_q;

    // extend source rotation; RotNone is the decoder's omitted case
    always_comb
    begin
        case (req.rotateRight)
            pack_extend_bitfield_pkg::Rot8:
                rotated = {req.secondSrcReg[7:0],
                    req.secondSrcReg[31:8]}; // RL5
            pack_extend_bitfield_pkg::Rot16:
                rotated = {req.secondSrcReg[15:0], req.secondSrcReg[31:16]};
            pack_extend_bitfield_pkg::Rot24:
                rotated = {req.secondSrcReg[23:0], req.secondSrcReg[31:24]};
            default:
                rotated = req.secondSrcReg; // RL6
        endcase
    end

    always_comb
    begin
        case (req.op)
            pack_extend_bitfield_pkg::OP_SIGN_EXT_BYTE,
            pack_extend_bitfield_pkg::OP_SIGN_EXT_BYTE_ADD:
                extVal = {{24{rotated[7]}}, rotated[7:0]}; // RL7
            pack_extend_bitfield_pkg::OP_ZERO_EXT_BYTE,
            pack_extend_bitfield_pkg::OP_ZERO_EXT_BYTE_ADD:
                extVal = {24'h000000, rotated[7:0]}; // RL7
            pack_extend_bitfield_pkg::OP_SIGN_EXT_HALF,
            pack_extend_bitfield_pkg::OP_SIGN_EXT_HALF_ADD:
                extVal = {{16{rotated[15]}}, rotated[15:0]}; // RL8
            pack_extend_bitfield_pkg::OP_ZERO_EXT_HALF,
            pack_extend_bitfield_pkg::OP_ZERO_EXT_HALF_ADD:
                extVal = {16'h0000, rotated[15:0]}; // RL8
            pack_extend_bitfield_pkg::OP_DUAL_SIGN_EXT_BYTE,
            pack_extend_bitfield_pkg::OP_DUAL_SIGN_EXT_BYTE_ADD:
                extVal = {{8{rotated[23]}}, rotated[23:16],
                    {8{rotated[7]}}, rotated[7:0]}; // RL9
            default:
                extVal = {8'h00, rotated[23:16], 8'h00, rotated[7:0]}; // RL9
        endcase
    end

    // pack shifts: zero amount is no shift for left, 32 for right
    always_comb
    begin
        shlWide = {32'h00000000, req.secondSrcReg} << req.shiftAmount; // RL2
        if (req.shiftAmount == pack_extend_bitfield_pkg::ShiftAsrFull)
        begin
            asrAmount = pack_extend_bitfield_pkg::AsrFullAmount; // RL4
        end
        else
        begin
            asrAmount = {1'b0, req.shiftAmount};
        end
        asrVal = $signed(req.secondSrcReg) >>> asrAmount; // RL4
        if (req.op == pack_extend_bitfield_pkg::OP_PACK_LOW_HIGH_SHIFT_LEFT)
        begin
            packVal = {shlWide[31:16], req.firstSrcReg[15:0]}; // RL1
        end
        else
        begin
            packVal = {req.firstSrcReg[31:16], asrVal[15:0]}; // RL3
        end
    end

    // field geometry; width 32 at lsb 0 gives an all-ones mask
    always_comb
    begin
        widthSum = {2'b00, req.fieldLsb} + {1'b0, req.fieldWidth};
        topBit = 6'(widthSum - 7'h01);
        badRange = (req.fieldWidth == 6'h00) || (widthSum > 7'h20); // RL15
        if (req.fieldWidth >= 6'h20)
        begin
            fieldMask = 32'hffffffff;
        end
        else
        begin
            fieldMask = (32'h00000001 << req.fieldWidth) - 32'h00000001;
        end
        fieldVal = (req.firstSrcReg >> req.fieldLsb) & fieldMask;
    end

    always_comb
    begin
        case (req.op)
            pack_extend_bitfield_pkg::OP_PACK_LOW_HIGH_SHIFT_LEFT,
            pack_extend_bitfield_pkg::OP_PACK_HIGH_LOW_SHIFT_RIGHT:
                result_d = packVal;
            pack_extend_bitfield_pkg::OP_SIGN_EXT_BYTE_ADD,
            pack_extend_bitfield_pkg::OP_SIGN_EXT_HALF_ADD,
            pack_extend_bitfield_pkg::OP_ZERO_EXT_BYTE_ADD,
            pack_extend_bitfield_pkg::OP_ZERO_EXT_HALF_ADD:
                result_d = req.firstSrcReg + extVal; // RL10 RL18
            pack_extend_bitfield_pkg::OP_DUAL_SIGN_EXT_BYTE_ADD,
            pack_extend_bitfield_pkg::OP_DUAL_ZERO_EXT_BYTE_ADD:
                // separate adders: a low-half carry must not reach the top
                result_d = {req.firstSrcReg[31:16] + extVal[31:16],
                    req.firstSrcReg[15:0] + extVal[15:0]}; // RL11 RL18
            pack_extend_bitfield_pkg::OP_FIELD_CLEAR:
                result_d = req.destOld & ~(fieldMask << req.fieldLsb); // RL13
            pack_extend_bitfield_pkg::OP_FIELD_INSERT:
                result_d = (req.destOld & ~(fieldMask << req.fieldLsb))
                    | ((req.firstSrcReg & fieldMask) << req.fieldLsb); // RL14
            pack_extend_bitfield_pkg::OP_SIGNED_FIELD_EXTRACT:
                if (req.firstSrcReg[topBit[4:0]])
                begin
                    result_d = fieldVal | ~fieldMask; // RL16
                end
                else
                begin
                    result_d = fieldVal;
                end
            pack_extend_bitfield_pkg::OP_UNSIGNED_FIELD_EXTRACT:
                result_d = fieldVal; // RL17
            default:
                result_d = extVal;
        endcase
    end

    assign isBitfield = (req.op == pack_extend_bitfield_pkg::OP_FIELD_CLEAR)
        || (req.op == pack_extend_bitfield_pkg::OP_FIELD_INSERT)
        || (req.op == pack_extend_bitfield_pkg::OP_SIGNED_FIELD_EXTRACT)
        || (req.op == pack_extend_bitfield_pkg::OP_UNSIGNED_FIELD_EXTRACT);

    // write-back stage; result holds its last value when nothing is written
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            writeEn_q <= 1'b0;
        end
        else
        begin
            writeEn_q <= req.valid && req.condPass; // RL19
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            result_q <= 32'h00000000;
        end
        else if (req.valid && req.condPass)
        begin
            result_q <= result_d; // RL19
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            flags_q <= 4'h0;
        end
        else
        begin
            flags_q <= req.flagsIn; // RL12
        end
    end

    // out-of-range field: result is still produced, only flagged
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rangeError_q <= 1'b0;
        end
        else
        begin
            rangeError_q <= req.valid && isBitfield && badRange; // RL15
        end
    end

    assign resp.writeEn = writeEn_q;
    assign resp.result = result_q;
    assign resp.flagsOut = flags_q;
    assign rangeError = rangeError_q;

    property p_cond_fail_no_write;
        @(posedge mclk) disable iff (rst)
        (req.valid && !req.condPass) |=> !resp.writeEn && $stable(resp.result);
    endproperty
    a_cond_fail_no_write: assert property (p_cond_fail_no_write) // RL19
        else $error("write issued for failed condition");

    property p_flags_pass;
        @(posedge mclk) disable iff (rst)
        1'b1 |=> resp.flagsOut == $past(req.flagsIn);
    endproperty
    a_flags_pass: assert property (p_flags_pass) // RL12
        else $error("flags altered");

    property p_pack_low_high;
        @(posedge mclk) disable iff (rst)
        (req.valid && req.condPass
            && req.op == pack_extend_bitfield_pkg::OP_PACK_LOW_HIGH_SHIFT_LEFT)
        |=> resp.result[15:0] == $past(req.firstSrcReg[15:0]);
    endproperty
    a_pack_low_high: assert property (p_pack_low_high) // RL1
        else $error("pack low-high low half wrong");

    property p_pack_full_asr;
        @(posedge mclk) disable iff (rst)
        (req.valid && req.condPass && req.shiftAmount == 5'h00
            && req.op
            == pack_extend_bitfield_pkg::OP_PACK_HIGH_LOW_SHIFT_RIGHT)
        |=> resp.result[15:0] == {16{$past(req.secondSrcReg[31])}};
    endproperty
    a_pack_full_asr: assert property (p_pack_full_asr) // RL4
        else $error("shift field zero is not a 32-bit shift");

    property p_zero_byte;
        @(posedge mclk) disable iff (rst)
        (req.valid && req.condPass
            && req.op == pack_extend_bitfield_pkg::OP_ZERO_EXT_BYTE)
        |=> resp.result[31:8] == 24'h000000;
    endproperty
    a_zero_byte: assert property (p_zero_byte) // RL7
        else $error("zero-extended byte has high bits");

    property p_no_rot;
        @(posedge mclk) disable iff (rst)
        (req.valid && req.condPass && req.rotateRight == 2'h0
            && req.op == pack_extend_bitfield_pkg::OP_SIGN_EXT_HALF)
        |=> resp.result == {{16{$past(req.secondSrcReg[15])}},
            $past(req.secondSrcReg[15:0])};
    endproperty
    a_no_rot: assert property (p_no_rot) // RL6
        else $error("halfword sign extension wrong");

    property p_dual_add;
        @(posedge mclk) disable iff (rst)
        (req.valid && req.condPass && req.rotateRight == 2'h0
            && req.op == pack_extend_bitfield_pkg::OP_DUAL_ZERO_EXT_BYTE_ADD)
        |=> resp.result[31:16] == 16'($past(req.firstSrcReg[31:16])
            + {8'h00, $past(req.secondSrcReg[23:16])});
    endproperty
    a_dual_add: assert property (p_dual_add) // RL11
        else $error("dual add top half wrong");

    property p_clear_keeps;
        @(posedge mclk) disable iff (rst)
        (req.valid && req.condPass && req.fieldLsb == 5'h08
            && req.fieldWidth == 6'h0c
            && req.op == pack_extend_bitfield_pkg::OP_FIELD_CLEAR)
        |=> resp.result == ($past(req.destOld) & 32'hfff000ff);
    endproperty
    a_clear_keeps: assert property (p_clear_keeps) // RL13
        else $error("field clear wrong");

    property p_range;
        @(posedge mclk) disable iff (rst)
        (req.valid && req.op == pack_extend_bitfield_pkg::OP_FIELD_INSERT
            && req.fieldWidth == 6'h00) |=> rangeError;
    endproperty
    a_range: assert property (p_range) // RL15
        else $error("zero width not flagged");

    c_pack: cover property (@(posedge mclk) disable iff (rst)
        req.valid
        && req.op == pack_extend_bitfield_pkg::OP_PACK_HIGH_LOW_SHIFT_RIGHT);
    c_ext_add: cover property (@(posedge mclk) disable iff (rst)
        req.valid && req.op == pack_extend_bitfield_pkg::OP_SIGN_EXT_BYTE_ADD);
    c_extract: cover property (@(posedge mclk) disable iff (rst)
        req.valid
        && req.op == pack_extend_bitfield_pkg::OP_SIGNED_FIELD_EXTRACT);
    c_cond_fail: cover property (@(posedge mclk) disable iff (rst)
        req.valid && !req.condPass);

endmodule

//--- regfile_model.sv
// register file stand-in: holds the destination and takes write-backs
`timescale 1ns/1ps
module regfile_model
(
    input wire logic mclk,
    input wire logic rst,
    input wire pack_extend_bitfield_pkg::resp_t resp,
    output logic [31:0] destOld_q
);
    // only reset or a granted write may change the destination
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            destOld_q <= 32'h0;
        else if (resp.writeEn)
            destOld_q <= resp.result;
    end
endmodule

//--- testbench.sv
// self-checking bench for the pack/extend/bitfield unit
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    pack_extend_bitfield_pkg::req_t req = '0;
    pack_extend_bitfield_pkg::resp_t resp;
    logic rangeError;
    logic [31:0] rfDest;
    logic [31:0] expRes = 32'h0;
    logic known = 1'b1;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    pack_extend_bitfield_unit DUT (.mclk(mclk), .rst(rst), .req(req),
        .resp(resp), .rangeError(rangeError));
    regfile_model rf (.mclk(mclk), .rst(rst), .resp(resp),
        .destOld_q(rfDest));

    always #50 mclk = ~mclk;

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            bad_count++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] ext(input logic [31:0] v,
        input int w, input logic s);
        logic signed [31:0] t;
        t = v << (32 - w);
        if (s)
            return t >>> (32 - w);
        return t >> (32 - w);
    endfunction

    function automatic logic [31:0] model(
        input pack_extend_bitfield_pkg::req_t r);
        logic [63:0] wide;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] x;
        logic [31:0] m;
        logic [15:0] h;
        logic [15:0] l;
        int k;
        logic s;
        logic add;
        a = r.firstSrcReg;
        b = r.secondSrcReg;
        wide = {b, b} >> (8 * r.rotateRight);
        x = wide[31:0];
        m = 32'(((64'h1 << r.fieldWidth) - 64'h1) << r.fieldLsb);
        add = r.op >= 5'h08;
        k = add ? r.op - 8 : r.op - 2;
        s = k < 3;
        case (r.op)
            5'h00:
            begin
                x = b << r.shiftAmount;
                return {x[31:16], a[15:0]};
            end
            5'h01:
            begin
                // field value zero stands for a full 32-bit shift
                k = (r.shiftAmount == 5'h00) ? 32 : int'(r.shiftAmount);
                wide = {{32{b[31]}}, b} >> k;
                return {a[31:16], wide[15:0]};
            end
            5'h0e: return r.destOld & ~m;
            5'h0f: return (r.destOld & ~m) | ((a << r.fieldLsb) & m);
            5'h10: return ext(a >> r.fieldLsb, int'(r.fieldWidth), 1'b1);
            5'h11: return ext(a >> r.fieldLsb, int'(r.fieldWidth), 1'b0);
            default:
            begin
                if (k % 3 == 2)
                begin
                    l = 16'(ext(x, 8, s)) + (add ? a[15:0] : 16'h0);
                    h = 16'(ext(x >> 16, 8, s)) + (add ? a[31:16] : 16'h0);
                    return {h, l};
                end
                return ext(x, (k % 3 == 1) ? 16 : 8, s) + (add ? a : 32'h0);
            end
        endcase
    endfunction

    task automatic issue(input logic [4:0] op, input logic [31:0] a,
        input logic [31:0] b, input logic [4:0] sh, input logic [1:0] rot,
        input logic [4:0] lsb, input logic [5:0] wid, input logic cp);
        pack_extend_bitfield_pkg::req_t r;
        logic bad;
        @(negedge mclk);
        if (known) check(rfDest, expRes);
        r = '{1'b1, cp, pack_extend_bitfield_pkg::op_t'(op), a, b, rfDest,
            sh, rot, lsb, wid, op[3:0]};
        bad = op >= 5'h0e && (wid == 6'h0 || lsb + wid > 32);
        @(posedge mclk);
        req <= r;
        @(posedge mclk);
        req.valid <= 1'b0;
        @(negedge mclk);
        check(32'(resp.writeEn), 32'(cp));
        check(32'(resp.flagsOut), 32'(r.flagsIn));
        check(32'(rangeError), 32'(bad));
        if (cp && !bad) expRes = model(r);
        // out-of-range geometry leaves the written value unpredictable
        if (cp) known = !bad;
        if (known) check(resp.result, expRes);
    endtask

    task automatic t_pack();
        issue(5'h00, 32'h1234_5678, 32'habcd_ef01, 5'd0, 0, 0, 0, 1);
        issue(5'h00, 32'h1234_5678, 32'habcd_ef01, 5'd1, 0, 0, 0, 1);
        issue(5'h00, 32'h1234_5678, 32'h0000_0001, 5'd31, 0, 0, 0, 1);
        issue(5'h01, 32'h1234_5678, 32'h8000_7f00, 5'd0, 0, 0, 0, 1);
        issue(5'h01, 32'h1234_5678, 32'h0000_8002, 5'd1, 0, 0, 0, 1);
        issue(5'h01, 32'h1234_5678, 32'h9abc_0000, 5'd16, 0, 0, 0, 1);
    endtask

    task automatic t_ext();
        for (int op = 2; op < 8; op++)
            for (int rot = 0; rot < 4; rot++)
                issue(5'(op), 0, 32'h8f7e_c1a3, 0, 2'(rot), 0, 0, 1);
    endtask

    task automatic t_add();
        for (int op = 8; op < 14; op++)
        begin
            issue(5'(op), 32'hffff_fff0, 32'h80ff_7f81, 0, 0, 0, 0, 1);
            issue(5'(op), 32'h7fff_ff80, 32'h80ff_7f81, 0, 2, 0, 0, 1);
        end
    endtask

    task automatic t_field();
        issue(5'h11, 32'hdead_beef, 0, 0, 0, 5'd0, 6'd32, 1);
        issue(5'h0e, 0, 0, 0, 0, 5'd8, 6'd12, 1);
        issue(5'h0f, 32'h0000_0abc, 0, 0, 0, 5'd8, 6'd12, 1);
        issue(5'h0f, 32'h0000_0005, 0, 0, 0, 5'd31, 6'd1, 1);
        issue(5'h10, 32'h00a0_0000, 0, 0, 0, 5'd20, 6'd4, 1);
        issue(5'h10, 32'h8000_0000, 0, 0, 0, 5'd31, 6'd1, 1);
        issue(5'h11, 32'hffff_ffff, 0, 0, 0, 5'd9, 6'd10, 1);
        issue(5'h0e, 0, 0, 0, 0, 5'd5, 6'd0, 1);
        issue(5'h11, 0, 0, 0, 0, 5'd16, 6'd17, 1);
        issue(5'h0f, 32'h0000_00ff, 0, 0, 0, 5'd4, 6'd0, 1);
        issue(5'h11, 32'h1357_9bdf, 0, 0, 0, 5'd0, 6'd32, 1);
    endtask

    task automatic t_cond();
        issue(5'h00, 32'h1111_2222, 32'h3333_4444, 0, 0, 0, 0, 0);
        issue(5'h0e, 0, 0, 0, 0, 5'd0, 6'd16, 0);
        issue(5'h08, 32'h1, 32'h2, 0, 0, 0, 0, 1);
    endtask

    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check(resp.result, 32'h0);
        check(32'({resp.writeEn, resp.flagsOut, rangeError}), 32'h0);
        t_pack();
        t_ext();
        t_add();
        t_field();
        t_cond();
        close_out();
    end
endmodule
